// ### core/head_maint_cmd.sv
// Command decoder for one channel's process-data command interface.
// Assumes the request is stable while its code is nonzero and the head
// answers a parameter word read in the same cycle that the access stands.
//
// Function
// R1: A restore command writes the stored backup into the head parameters.
// R2: A backup command copies the head's current settings into storage.
// R3: The stored backup survives a voltage reset of the interface.
// R4: The host issues a backup before any restore.
// R5: The host restores only into a head of matching type and firmware.
// R6: The host uses backup and restore only on UHF configurations.
// R7: Reset resets head and interface; start address 0 soft, 1 voltage.
// R8: Reset clears input data, output data and the internal buffer.
// R9: Backup, restore and reset answer with a code equal to the command.
// R10: A read command is acknowledged at once with the busy-read code.
// R11: A pending read waits for a tag in range and then runs.
// R12: Unneeded fields of backup, restore and reset are ignored.
`timescale 1ns/10ps
module head_maint_cmd
  import head_cmd_pkg::*;
(
  input  wire logic         CLK,
  input  wire logic         RESET,
  input  wire request_t     REQ,
  input  wire logic         TAG_IN_RANGE,
  input  wire logic [15:0]  HEAD_RDATA,
  output head_access_t      HEAD_ACC,
  output logic              HEAD_SOFT_RST,
  output logic              HEAD_PWR_RST,
  output logic              CLEAR_PD,
  output response_t         RSP
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_BACKUP  = 3'b001,
    ST_RESTORE = 3'b010,
    ST_READ    = 3'b011,
    ST_RESET   = 3'b100,
    ST_DONE    = 3'b101
  } state_t;

  state_t          state, next_state;
  logic [SET_AW:0] idx, next_idx;
  logic [15:0]     last_cmd, next_last_cmd;
  logic            rst_kind, next_rst_kind;
  logic [7:0]      rcnt, next_rcnt;
  head_access_t    next_acc;
  response_t       next_rsp;
  logic            next_soft, next_pwr, next_clr;
  logic            st_we;
  logic [SET_AW-1:0] st_addr;
  logic [15:0]     st_rdata;

  // Backup memory; it carries no reset input.
  settings_store #(.WORDS(SET_WORDS), .AW(SET_AW)) u_store (
    .CLK   (CLK),
    .we    (st_we),
    .addr  (st_addr),
    .wdata (HEAD_RDATA),
    .rdata (st_rdata)
  );

  // Backup writes the word the head returned for the previous read.
  always_comb begin
    st_we   = (state == ST_BACKUP) && (idx != '0);   // R2
    st_addr = (state == ST_BACKUP) ? SET_AW'(idx - 1'b1)
                                   : idx[SET_AW-1:0];
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // A new command is recognised only when the code changes, so a held
  // request does not rerun; the host writes zero between commands.
  always_comb begin
    next_state    = state;
    next_idx      = idx;
    next_last_cmd = REQ.cmd_code;
    next_rst_kind = rst_kind;
    next_rcnt     = rcnt;
    next_acc      = '0;
    next_rsp      = RSP;
    next_soft     = 1'b0;
    next_pwr      = 1'b0;
    next_clr      = 1'b0;
    next_rsp.tag_present = TAG_IN_RANGE;
    next_rsp.loop_cnt    = REQ.loop_cnt;
    case (state)
      ST_IDLE: begin
        next_idx = '0;
        if (REQ.cmd_code != last_cmd) begin
          case (REQ.cmd_code)
            CMD_BACKUP: begin
              next_state = ST_BACKUP;
            end
            CMD_RESTORE: begin
              next_state = ST_RESTORE;
            end
            CMD_RESET: begin
              // Only the low bit of start address picks the kind.
              next_rst_kind = REQ.start_addr[0];       // R7 R12
              next_state    = ST_RESET;
            end
            CMD_READ: begin
              next_rsp.rsp_code = RSP_BUSY_RD;         // R10
              next_state        = ST_READ;
            end
            default: begin
              next_rsp.rsp_code = REQ.cmd_code;
            end
          endcase
        end
      end
      ST_BACKUP: begin
        // Read head words one ahead of the store write.
        if (idx < (SET_AW+1)'(SET_WORDS)) begin
          next_acc.re   = 1'b1;
          next_acc.addr = idx[SET_AW-1:0];
        end
        next_idx = idx + 1'b1;
        if (idx == (SET_AW+1)'(SET_WORDS)) begin
          next_rsp.rsp_code = CMD_BACKUP;              // R9
          next_state        = ST_DONE;
        end
      end
      ST_RESTORE: begin
        // Store data lags address by one cycle.
        if (idx != '0) begin
          next_acc.we    = 1'b1;                       // R1
          next_acc.addr  = SET_AW'(idx - 1'b1);
          next_acc.wdata = st_rdata;
        end
        next_idx = idx + 1'b1;
        if (idx == (SET_AW+1)'(SET_WORDS)) begin
          next_rsp.rsp_code = CMD_RESTORE;             // R9
          next_state        = ST_DONE;
        end
      end
      ST_READ: begin
        if (TAG_IN_RANGE) begin                        // R11
          next_acc.re        = 1'b1;
          next_rsp.read_data = HEAD_RDATA;
          next_rsp.rsp_code  = CMD_READ;
          next_state         = ST_DONE;
        end
      end
      ST_RESET: begin
        next_soft = (rst_kind == RST_SOFT[0]);
        next_pwr  = (rst_kind == RST_VOLTAGE[0]);
        next_clr  = 1'b1;                              // R8
        next_rcnt = rcnt + 1'b1;
        if (rcnt == 8'(RESET_CYC - 1)) begin
          next_rcnt            = '0;
          next_rsp.read_data   = ZERO16;               // R8
          next_rsp.error_code  = ZERO16;
          next_rsp.rsp_code    = CMD_RESET;            // R9
          next_state           = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers only; every output comes straight from a flip-flop.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state         <= ST_IDLE;
      idx           <= '0;
      last_cmd      <= CMD_IDLE;
      rst_kind      <= 1'b0;
      rcnt          <= '0;
      HEAD_ACC      <= '0;
      RSP           <= '0;
      HEAD_SOFT_RST <= 1'b0;
      HEAD_PWR_RST  <= 1'b0;
      CLEAR_PD      <= 1'b0;
    end else begin
      state         <= next_state;
      idx           <= next_idx;
      last_cmd      <= next_last_cmd;
      rst_kind      <= next_rst_kind;
      rcnt          <= next_rcnt;
      HEAD_ACC      <= next_acc;
      RSP           <= next_rsp;
      HEAD_SOFT_RST <= next_soft;
      HEAD_PWR_RST  <= next_pwr;
      CLEAR_PD      <= next_clr;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_read_taken;
    state == ST_IDLE && REQ.cmd_code == CMD_READ && last_cmd != CMD_READ;
  endsequence

  AST_BUSY_ACK: assert property (@(posedge CLK) disable iff (RESET) // R10
    s_read_taken |=> RSP.rsp_code == RSP_BUSY_RD)
    else $error("Read not acknowledged as busy.");

  AST_READ_WAIT: assert property (@(posedge CLK) disable iff (RESET) // R11
    state == ST_READ && !TAG_IN_RANGE |=> state == ST_READ)
    else $error("Read left without a tag.");

  AST_READ_RUN: assert property (@(posedge CLK) disable iff (RESET) // R11
    state == ST_READ && TAG_IN_RANGE |=> HEAD_ACC.re && state == ST_DONE)
    else $error("Read not run on tag.");

  AST_BACKUP_ECHO: assert property (@(posedge CLK) disable iff (RESET) // R9
    state == ST_IDLE && REQ.cmd_code == CMD_BACKUP && last_cmd != CMD_BACKUP
    |-> ##10 RSP.rsp_code == CMD_BACKUP)
    else $error("Backup code not echoed.");

  AST_RESTORE_WR: assert property (@(posedge CLK) disable iff (RESET) // R1
    state == ST_RESTORE && idx != '0 |=> HEAD_ACC.we)
    else $error("Restore did not write head.");

  AST_BACKUP_ST: assert property (@(posedge CLK) disable iff (RESET) // R2
    state == ST_BACKUP && idx == '0 |=> st_we)
    else $error("Backup did not store.");

  AST_RESET_KIND: assert property (@(posedge CLK) disable iff (RESET) // R7
    state == ST_RESET |=> HEAD_PWR_RST == $past(rst_kind)
    && HEAD_SOFT_RST == !$past(rst_kind))
    else $error("Wrong reset kind.");

  AST_RESET_CLR: assert property (@(posedge CLK) disable iff (RESET) // R8
    state == ST_RESET && rcnt == 8'(RESET_CYC - 1)
    |=> CLEAR_PD && RSP.read_data == ZERO16 && RSP.rsp_code == CMD_RESET)
    else $error("Reset did not clear data.");

  AST_IGNORE: assert property (@(posedge CLK) disable iff (RESET) // R12
    state == ST_BACKUP |=> !HEAD_ACC.we)
    else $error("Backup wrote head.");

endmodule

// ### core/head_cmd_pkg.sv
// Package for the per-channel head maintenance command decoder.
// Assumes one clock domain; all values are shared by both design files.
package head_cmd_pkg;

  // ------------------------------------------------------------------
  // Command and response codes
  // ------------------------------------------------------------------
  localparam logic [15:0] CMD_IDLE    = 16'h0000;
  localparam logic [15:0] CMD_READ    = 16'h0002;
  localparam logic [15:0] CMD_RESTORE = 16'h1000;
  localparam logic [15:0] CMD_BACKUP  = 16'h1001;
  localparam logic [15:0] CMD_RESET   = 16'h8000;
  localparam logic [15:0] RSP_BUSY_RD = 16'h8002;

  // Reset kind selected by the start-address field.
  localparam logic [15:0] RST_SOFT    = 16'h0000;
  localparam logic [15:0] RST_VOLTAGE = 16'h0001;

  // ------------------------------------------------------------------
  // Sizes and timing
  // ------------------------------------------------------------------
  localparam int SET_WORDS   = 8;
  localparam int SET_AW      = 3;
  localparam int RESET_NS    = 100;
  localparam int CLK_NS      = 10;
  localparam int RESET_CYC   = (RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // Request written by the host into output process data.
  typedef struct packed {
    logic [7:0]  loop_cnt;
    logic [15:0] cmd_code;
    logic [7:0]  head_addr;
    logic [7:0]  uid_len;
    logic [15:0] start_addr;
    logic [15:0] length;
  } request_t;

  // Answer shown to the host in input process data.
  typedef struct packed {
    logic [7:0]  loop_cnt;
    logic [15:0] rsp_code;
    logic [15:0] error_code;
    logic        tag_present;
    logic [15:0] read_data;
  } response_t;

  // Parameter word access toward the attached head.
  typedef struct packed {
    logic              we;
    logic              re;
    logic [SET_AW-1:0] addr;
    logic [15:0]       wdata;
  } head_access_t;

endpackage

// ### core/settings_store.sv
// Backup store for head settings, written word by word.
// Assumes the contents survive RESET, standing for nonvolatile memory.
`timescale 1ns/10ps
module settings_store
  import head_cmd_pkg::*;
#(
  parameter int WORDS = SET_WORDS,
  parameter int AW    = SET_AW
) (
  input  wire logic          CLK,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   wdata,
  output logic      [15:0]   rdata
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [15:0] mem [WORDS];
  logic [15:0] next_rdata;

  // Combinational read; registered below.
  always_comb begin
    next_rdata = mem[addr];
  end

  // No reset here on purpose: a voltage reset must not lose the backup.
  always_ff @(posedge CLK) begin
    if (we) begin
      mem[addr] <= wdata;   // R3
    end
    rdata <= next_rdata;
  end

endmodule

// ### testbench/head_model.sv
// Behavioural model of the attached head's settings words.
// Assumes one access per cycle; a read is answered while the access stands.
`timescale 1ns/10ps
module head_model
  import head_cmd_pkg::*;
(
  input  wire logic         CLK,
  input  wire head_access_t acc,
  output logic [15:0]       rdata
);
  // ------------------------------------------------------------------
  // Parameter words
  // ------------------------------------------------------------------
  logic [15:0] mem [SET_WORDS];
  logic [15:0] last = 16'h0000;

  // The same head serves backup and restore, so type and firmware match.
  always @(posedge CLK) begin
    if (acc.we) begin
      mem[acc.addr] <= acc.wdata;
    end
    if (acc.re) begin
      last <= mem[acc.addr];
    end
  end

  // The word stands while the read access stands; a backup stores it at
  // the edge that ends that cycle.
  // Outside an answer the bus shows the inverse, so stale data never passes.
  assign rdata = acc.re ? mem[acc.addr] : ~last;
endmodule

// ### testbench/tb_head_maint_cmd.sv
// Self-checking bench for the head maintenance command decoder.
// Assumes the head model answers parameter reads while the access stands.
`timescale 1ns/10ps
module tb_head_maint_cmd
  import head_cmd_pkg::*;
;
  logic         CLK = 1'b0;
  logic         RESET = 1'b1;
  request_t     REQ = '0;
  logic         TAG_IN_RANGE = 1'b0;
  logic [15:0]  HEAD_RDATA;
  head_access_t HEAD_ACC;
  logic         HEAD_SOFT_RST;
  logic         HEAD_PWR_RST;
  logic         CLEAR_PD;
  response_t    RSP;
  int           n_fail = 0;
  int           comparisons = 0;
  int           n_clr, n_soft, n_pwr, n_re, n_we, n;
  logic [15:0]  gold [SET_WORDS];

  always #5 CLK = ~CLK;

  head_maint_cmd head_maint_cmd_i (.CLK(CLK), .RESET(RESET), .REQ(REQ),
    .TAG_IN_RANGE(TAG_IN_RANGE), .HEAD_RDATA(HEAD_RDATA),
    .HEAD_ACC(HEAD_ACC), .HEAD_SOFT_RST(HEAD_SOFT_RST),
    .HEAD_PWR_RST(HEAD_PWR_RST), .CLEAR_PD(CLEAR_PD), .RSP(RSP));

  head_model head_model_i (.CLK(CLK), .acc(HEAD_ACC), .rdata(HEAD_RDATA));

  // Pulse counters, cleared by the bench between edges.
  always @(posedge CLK) begin
    if (CLEAR_PD === 1'b1) n_clr++;
    if (HEAD_SOFT_RST === 1'b1) n_soft++;
    if (HEAD_PWR_RST === 1'b1) n_pwr++;
    if (HEAD_ACC.re === 1'b1) n_re++;
    if (HEAD_ACC.we === 1'b1) n_we++;
  end

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task report_and_stop();
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task check(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // Counts edges until the response code shows, bounded.
  task wait_code(input logic [15:0] exp);
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (RSP.rsp_code !== exp && n < 40);
  endtask

  // Unneeded fields carry random junk, except the upper start-address bits of a reset, which are zero.
  task run(input logic [15:0] code, input logic [15:0] start,
           input logic [15:0] exp, input int lat);
    REQ.cmd_code = CMD_IDLE;
    repeat (2) @(posedge CLK);
    #1;
    {n_clr, n_soft, n_pwr, n_re, n_we} = '0;
    REQ = '{loop_cnt: 8'($urandom), cmd_code: code,
      head_addr: 8'($urandom), uid_len: 8'($urandom),
      start_addr: start, length: 16'($urandom)};
    wait_code(exp);
    check(n == lat, "answer latency");
    check(RSP.loop_cnt === REQ.loop_cnt, "loop counter echo");
    // One more edge lets the last pulse be counted and the last write land.
    @(posedge CLK);
    #1;
  endtask

  task head_ok();
    for (int i = 0; i < SET_WORDS; i++) begin
      check(head_model_i.mem[i] === gold[i], "head settings");
      head_model_i.mem[i] = ~gold[i];
    end
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(64994));
    repeat (6) @(posedge CLK);
    #1 RESET = 1'b0;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < SET_WORDS; i++) begin
        gold[i] = 16'($urandom);
        head_model_i.mem[i] = gold[i];
      end
      run(CMD_BACKUP, 16'($urandom), CMD_BACKUP, 10);
      check(n_re == SET_WORDS, "backup reads");
      for (int i = 0; i < SET_WORDS; i++) head_model_i.mem[i] = ~gold[i];
      run(CMD_RESTORE, 16'($urandom), CMD_RESTORE, 10);
      check(n_we == SET_WORDS, "restore writes");
      head_ok();
      run(CMD_RESET, 16'(r), CMD_RESET, 11);
      check(n_clr == RESET_CYC, "clear pulse");
      check(n_soft == (r ? 0 : RESET_CYC), "soft reset");
      check(n_pwr == (r ? RESET_CYC : 0), "voltage reset");
      check(RSP.read_data === ZERO16, "read data cleared");
      check(RSP.error_code === ZERO16, "error cleared");
      run(CMD_READ, 16'($urandom), RSP_BUSY_RD, 1);
      repeat ($urandom_range(3, 12)) @(posedge CLK);
      #1;
      check(RSP.rsp_code === RSP_BUSY_RD, "read held");
      check(RSP.tag_present === 1'b0, "tag flag while absent");
      TAG_IN_RANGE = 1'b1;
      wait_code(CMD_READ);
      check(n == 1, "read after tag");
      check(RSP.tag_present === 1'b1, "tag flag while present");
      TAG_IN_RANGE = 1'b0;
    end
    // Backup must outlive an interface reset. The read code is withdrawn
    // first, or it would be taken again after release and hang the decoder.
    REQ.cmd_code = CMD_IDLE;
    RESET = 1'b1;
    repeat (2) @(posedge CLK);
    #1 RESET = 1'b0;
    run(CMD_RESTORE, 16'($urandom), CMD_RESTORE, 10);
    head_ok();
    report_and_stop();
  end

  // Watchdog well beyond the at most 135 cycles the tests need.
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
endmodule
